// ==== design/sscg_regs.svh ====
`ifndef SSCG_REGS_SVH
`define SSCG_REGS_SVH

`define SSCG_LFSR_BITS   15
`define SSCG_DAC_BITS    7
`define SSCG_LFSR_SEED   15'h0001
`define SSCG_DAC_MID     7'h40
`define SSCG_MUTE_LAST   7'h3f
`define SSCG_N16_LAST    8'h1f
`define SSCG_N32_LAST    8'h3f
`define SSCG_N64_LAST    8'h7f
`define SSCG_AC_WIN_LAST 6'h3f
`define SSCG_AC_EDGE_MIN 7'h10
`define SSCG_SINCE_MAX   7'h7f
`define SSCG_UNMUTE_AT   7'h41

`endif

// ==== design/sscg_pkg.sv ====
`include "sscg_regs.svh"
package sscg_pkg;
	typedef enum logic [1:0] {
		SSCG_LVL_LOW,
		SSCG_LVL_FLOAT,
		SSCG_LVL_HIGH
	} sscg_rate_lvl_t;

	typedef struct packed {
		logic                        active;
		logic [`SSCG_DAC_BITS-1:0]   dac;
	} sscg_mod_t;
endpackage : sscg_pkg

// ==== design/sscg_lfsr.sv ====
`timescale 1ns/1ps
`include "sscg_regs.svh"
module sscg_lfsr import sscg_pkg::*; #(
	parameter int WIDTH = `SSCG_LFSR_BITS
) (
	input  wire logic             core_clk,
	input  wire logic             srst,
	input  wire logic             advance,
	output logic [WIDTH-1:0]      state
);
	logic [WIDTH-1:0] state_d;

	generate
		if (WIDTH != `SSCG_LFSR_BITS) begin : g_bad_width
			$error("sscg_lfsr: feedback taps only serve a 15-stage register");
		end
	endgenerate

	// Taps x^15 + x^14 + 1 give the maximal length of 2^15 - 1 steps.
	always_comb begin
		state_d = state;
		if (advance) begin
			state_d = {state[WIDTH-2:0], state[WIDTH-1] ^ state[WIDTH-2]};
		end
	end

	always_ff @(posedge core_clk) begin
		if (srst) begin
			state <= `SSCG_LFSR_SEED;
		end else begin
			state <= state_d;
		end
	end

	a_lfsr_never_zero: assert property (@(posedge core_clk) disable iff (srst)
		state != '0) else $error("shift register reached the all-zero state");
	a_lfsr_shift_step: assert property (@(posedge core_clk) disable iff (srst)
		advance |=> state == {$past(state[WIDTH-2:0]), $past(state[WIDTH-1]) ^ $past(state[WIDTH-2])})
		else $error("shift register step does not follow the feedback taps");
	a_lfsr_hold_idle: assert property (@(posedge core_clk) disable iff (srst)
		!advance |=> $stable(state)) else $error("shift register moved without a tick");
endmodule : sscg_lfsr

// ==== design/sscg_top.sv ====
`timescale 1ns/1ps
`include "sscg_regs.svh"
// Summary of operation
// - Each output toggles once per master cycle, giving half the master frequency.
// - Outputs sit high one master period and low one master period.
// - Complementary variant: second output is always the inverse of the first.
// - Quadrature variant: second output lags the first by a quarter output period.
// - First 64 cycles after reset: output A low, output B high.
// - Rate select low, float, high picks divider 16, 32, 64; level held outside.
// - Output-rate toggling on the rate select input stops spread modulation.
// - Pseudorandom sequence comes from a fifteen-stage linear feedback shift register.
// - Sequence repeats after 2^15-1 steps, that is times N output cycles.
// - Shift register advances once per tick of output clock divided by N, only while modulation is active.
// - Seven register bits form the DAC code, new on every step.
// - DAC code maps uniformly onto 0.9 to 1.1 of nominal frequency.
module sscg_top import sscg_pkg::*; #(
	parameter bit QUADRATURE = 1'b0
) (
	input  wire logic           core_clk,
	input  wire logic           srst,
	input  wire sscg_rate_lvl_t rateSelectInput,
	output logic                clockOutA,
	output logic                clockOutB,
	output sscg_mod_t           modStatus
);
	logic [6:0]                     muteCnt_q;
	logic [6:0]                     muteCnt_d;
	logic                           muted_q;
	logic                           muted_d;
	logic                           clockOutA_d;
	logic [7:0]                     tickCnt_q;
	logic [7:0]                     tickCnt_d;
	logic                           modTick_q;
	logic                           modTick_d;
	logic                           selPrev_q;
	logic                           selHigh;
	logic [5:0]                     winCnt_q;
	logic [5:0]                     winCnt_d;
	logic [6:0]                     edgeCnt_q;
	logic [6:0]                     edgeCnt_d;
	logic                           winEnd;
	sscg_mod_t                      modStatus_d;
	logic [`SSCG_LFSR_BITS-1:0]     lfsrState;

	// The result is the last master-cycle count of one tick, 2N - 1.
	function automatic logic [7:0] rateLimit(input sscg_rate_lvl_t lvl);
		unique case (lvl)
			SSCG_LVL_LOW:   rateLimit = `SSCG_N16_LAST;
			SSCG_LVL_FLOAT: rateLimit = `SSCG_N32_LAST;
			SSCG_LVL_HIGH:  rateLimit = `SSCG_N64_LAST;
			default:        rateLimit = `SSCG_N64_LAST;
		endcase
	endfunction : rateLimit

	// Startup mute and output divider; core_clk is the master oscillator itself.
	always_comb begin
		muteCnt_d   = muteCnt_q;
		muted_d     = muted_q;
		clockOutA_d = 1'b0;
		if (muted_q) begin
			muteCnt_d = muteCnt_q + 7'h01;
			if (muteCnt_q == `SSCG_MUTE_LAST) begin
				muted_d = 1'b0;
			end
		end else begin
			clockOutA_d = ~clockOutA;
		end
	end

	always_ff @(posedge core_clk) begin
		if (srst) begin
			muteCnt_q <= '0;
			muted_q   <= 1'b1;
			clockOutA <= 1'b0;
		end else begin
			muteCnt_q <= muteCnt_d;
			muted_q   <= muted_d;
			clockOutA <= clockOutA_d;
		end
	end

	generate
		if (QUADRATURE) begin : g_quad
			logic quadRun_q;
			logic quadRun_d;
			logic quadB_d;
			// Half a master cycle is a quarter output period, so B is retimed on the falling edge.
			// B waits for the first rising edge of A, because following A at once would cut a half-cycle runt.
			always_comb begin
				quadRun_d = !muted_q;
				quadB_d   = quadRun_q ? clockOutA : 1'b1;
			end
			always_ff @(posedge core_clk) begin
				if (srst) begin
					quadRun_q <= 1'b0;
				end else begin
					quadRun_q <= quadRun_d;
				end
			end
			always_ff @(negedge core_clk) begin
				if (srst) begin
					clockOutB <= 1'b1;
				end else begin
					clockOutB <= quadB_d;
				end
			end
			a_quad_align_rise: assert property (@(posedge core_clk) disable iff (srst)
				!muted_q && !$past(muted_q) |-> clockOutB == clockOutA)
				else $error("quadrature output not settled at master rising edge");
			a_quad_split_fall: assert property (@(negedge core_clk) disable iff (srst)
				!muted_q && $past(!muted_q, 2) |-> clockOutB != clockOutA)
				else $error("quadrature output not lagging by a quarter period");
		end else begin : g_comp
			logic compB_d;
			always_comb begin
				compB_d = ~clockOutA_d;
			end
			always_ff @(posedge core_clk) begin
				if (srst) begin
					clockOutB <= 1'b1;
				end else begin
					clockOutB <= compB_d;
				end
			end
			a_anti_phase_pair: assert property (@(posedge core_clk) disable iff (srst)
				clockOutB == !clockOutA) else $error("complementary outputs not in antiphase");
		end
	endgenerate

	// Tick divider: one tick per N output cycles, that is 2N master cycles.
	always_comb begin
		tickCnt_d = tickCnt_q + 8'h01;
		modTick_d = 1'b0;
		if (muted_q) begin
			tickCnt_d = '0;
		end else if (tickCnt_q >= rateLimit(rateSelectInput)) begin
			tickCnt_d = '0;
			modTick_d = 1'b1;
		end
	end

	// AC detector: an output tied back changes level every master cycle, 63 edges counted per 64-cycle window.
	// A static strap gives none, so a threshold of 16 separates them with margin.
	assign selHigh = (rateSelectInput == SSCG_LVL_HIGH);
	assign winEnd  = (winCnt_q == `SSCG_AC_WIN_LAST);

	always_comb begin
		winCnt_d  = winCnt_q + 6'h01;
		edgeCnt_d = edgeCnt_q + {6'h00, selHigh ^ selPrev_q};
		if (winEnd) begin
			edgeCnt_d = '0;
		end
	end

	// Modulation status and DAC code, both register outputs.
	always_comb begin
		modStatus_d = modStatus;
		if (winEnd) begin
			modStatus_d.active = (edgeCnt_q < `SSCG_AC_EDGE_MIN);
		end
		// The code is the low seven stages; the analog side scales it to 0.9..1.1 f.
		modStatus_d.dac = modStatus_d.active ? lfsrState[`SSCG_DAC_BITS-1:0] : `SSCG_DAC_MID;
	end

	always_ff @(posedge core_clk) begin
		if (srst) begin
			tickCnt_q <= '0;
			modTick_q <= 1'b0;
			selPrev_q <= selHigh;
			winCnt_q  <= '0;
			edgeCnt_q <= '0;
			modStatus <= '{active: 1'b1, dac: `SSCG_DAC_MID};
		end else begin
			tickCnt_q <= tickCnt_d;
			modTick_q <= modTick_d;
			selPrev_q <= selHigh;
			winCnt_q  <= winCnt_d;
			edgeCnt_q <= edgeCnt_d;
			modStatus <= modStatus_d;
		end
	end

	sscg_lfsr #(
		.WIDTH(`SSCG_LFSR_BITS)
	) u_lfsr (
		.core_clk(core_clk),
		.srst    (srst),
		.advance (modTick_q & modStatus.active),
		.state   (lfsrState)
	);

	// Helper logic read only by the checks below.
	logic [6:0]     sinceRst_q;
	logic [7:0]     tickGap_q;
	logic           gapValid_q;
	sscg_rate_lvl_t lvlPrev_q;

	always_ff @(posedge core_clk) begin
		if (srst) begin
			sinceRst_q <= '0;
			tickGap_q  <= '0;
			gapValid_q <= 1'b0;
			lvlPrev_q  <= SSCG_LVL_LOW;
		end else begin
			sinceRst_q <= (sinceRst_q == `SSCG_SINCE_MAX) ? sinceRst_q : sinceRst_q + 7'h01;
			tickGap_q  <= modTick_q ? 8'h00 : tickGap_q + 8'h01;
			gapValid_q <= (rateSelectInput != lvlPrev_q) ? 1'b0 : (modTick_q | gapValid_q);
			lvlPrev_q  <= rateSelectInput;
		end
	end

	a_mute_hold_low: assert property (@(posedge core_clk) disable iff (srst)
		sinceRst_q < `SSCG_UNMUTE_AT |-> !clockOutA && clockOutB)
		else $error("outputs left the mute state too early");
	a_mute_release: assert property (@(posedge core_clk) disable iff (srst)
		sinceRst_q == `SSCG_UNMUTE_AT |-> clockOutA) else $error("output A did not start after mute");
	a_half_toggle: assert property (@(posedge core_clk) disable iff (srst)
		!muted_q && !$past(muted_q) |-> clockOutA != $past(clockOutA))
		else $error("output A not toggling every master cycle");
	a_duty_half: assert property (@(posedge core_clk) disable iff (srst)
		$rose(clockOutA) && !muted_q |=> $fell(clockOutA) ##1 $rose(clockOutA))
		else $error("output A duty is not one master period each way");
	a_tick_spacing: assert property (@(posedge core_clk) disable iff (srst)
		modTick_q && gapValid_q && rateSelectInput == lvlPrev_q |-> tickGap_q == rateLimit(rateSelectInput))
		else $error("modulation tick spacing does not match the divider");
	a_ac_stop_mod: assert property (@(posedge core_clk) disable iff (srst)
		winEnd && edgeCnt_q >= `SSCG_AC_EDGE_MIN |=> !modStatus.active && modStatus.dac == `SSCG_DAC_MID)
		else $error("modulation not stopped by toggling rate select input");
	a_off_mid_scale: assert property (@(posedge core_clk) disable iff (srst)
		!modStatus.active |-> modStatus.dac == `SSCG_DAC_MID) else $error("DAC not mid-scale while off");
	a_dac_follows: assert property (@(posedge core_clk) disable iff (srst)
		modStatus.active && !$past(srst) |-> modStatus.dac == $past(lfsrState[`SSCG_DAC_BITS-1:0]))
		else $error("DAC code does not follow the shift register");

	c_unmute: cover property (@(posedge core_clk) disable iff (srst) $fell(muted_q));
	c_mod_tick: cover property (@(posedge core_clk) disable iff (srst) modTick_q && modStatus.active);
	c_mod_stop: cover property (@(posedge core_clk) disable iff (srst) $fell(modStatus.active));
	c_mod_resume: cover property (@(posedge core_clk) disable iff (srst) $rose(modStatus.active));
endmodule : sscg_top

// ==== testbench/sscg_far_side.sv ====
`timescale 1ns/1ps
module sscg_far_side import sscg_pkg::*; (
	input  wire logic           feedBack,
	input  wire sscg_rate_lvl_t level,
	input  wire logic           clockTap,
	output sscg_rate_lvl_t      rateSelectInput
);
	// A tapped output swings the pin rail to rail; otherwise the strap holds its level steadily.
	assign rateSelectInput = feedBack ? (clockTap ? SSCG_LVL_HIGH : SSCG_LVL_LOW) : level;
endmodule : sscg_far_side

// ==== testbench/spread_spectrum_clock_gen_tb.sv ====
`timescale 1ns/1ps
`include "sscg_regs.svh"
module spread_spectrum_clock_gen_tb import sscg_pkg::*;;
	logic           core_clk;
	logic           srst;
	logic           feedBack;
	logic           lastA;
	logic           clockOutA;
	logic           clockOutB;
	logic           clockOutAQ;
	logic           clockOutBQ;
	sscg_rate_lvl_t level;
	sscg_rate_lvl_t rateSelectInput;
	sscg_mod_t      modStatus;
	sscg_mod_t      modStatusQ;
	logic [14:0]    lfsr;
	int             miscompares;
	int             checked;

	sscg_top #(.QUADRATURE(1'b0)) DUT (.core_clk(core_clk), .srst(srst), .rateSelectInput(rateSelectInput),
		.clockOutA(clockOutA), .clockOutB(clockOutB), .modStatus(modStatus));
	sscg_top #(.QUADRATURE(1'b1)) DUTQ (.core_clk(core_clk), .srst(srst), .rateSelectInput(rateSelectInput),
		.clockOutA(clockOutAQ), .clockOutB(clockOutBQ), .modStatus(modStatusQ));
	sscg_far_side partner (.feedBack(feedBack), .level(level), .clockTap(clockOutA),
		.rateSelectInput(rateSelectInput));

	initial begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end

	function automatic logic [14:0] nextLfsr(input logic [14:0] s);
		return {s[13:0], s[14] ^ s[13]};
	endfunction : nextLfsr

	function automatic int divOf(input sscg_rate_lvl_t l);
		return (l == SSCG_LVL_LOW) ? 16 : (l == SSCG_LVL_FLOAT) ? 32 : 64;
	endfunction : divOf

	task automatic chkBit(input string name, input logic exp, input logic got);
		checked++;
		if (got !== exp) begin
			miscompares++;
			$display("mismatch %s expected %b seen %b", name, exp, got);
		end
	endtask : chkBit

	task automatic chkDac(input string name, input logic [6:0] exp, input logic [6:0] got);
		checked++;
		if (got !== exp) begin
			miscompares++;
			$display("mismatch %s expected %h seen %h", name, exp, got);
		end
	endtask : chkDac

	task automatic wrap_up;
		$display("checked %0d miscompares %0d", checked, miscompares);
		if (miscompares == 0 && checked > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : wrap_up

	// One master cycle, checking phase at both master edges.
	task automatic step;
		@(posedge core_clk);
		#1;
		chkBit("compB", ~clockOutA, clockOutB);
		chkBit("quadBpos", ~clockOutAQ, clockOutBQ);
		chkBit("toggleA", ~lastA, clockOutA);
		chkBit("toggleAQ", ~lastA, clockOutAQ);
		lastA = clockOutA;
		@(negedge core_clk);
		#1;
		chkBit("quadBneg", clockOutAQ, clockOutBQ);
	endtask : step

	task automatic restart(input sscg_rate_lvl_t l, input logic fb);
		int cnt;
		level = l;
		feedBack = fb;
		srst = 1'b1;
		repeat (16) @(negedge core_clk);
		chkDac("resetDac", `SSCG_DAC_MID, modStatus.dac);
		srst = 1'b0;
		cnt = 0;
		while (clockOutA !== 1'b1 && cnt < 80) begin
			@(posedge core_clk);
			#1;
			cnt++;
			if (cnt <= 64) begin
				chkBit("muteA", 1'b0, clockOutA);
				chkBit("muteB", 1'b1, clockOutB);
				chkBit("muteBq", 1'b1, clockOutBQ);
			end
		end
		chkBit("unmuteAt", 1'b1, cnt >= 65 && cnt <= 66);
		lastA = clockOutA;
	endtask : restart

	// Finds the first step, then samples mid-way between steps, which sit 2N master cycles apart.
	task automatic modRun(input sscg_rate_lvl_t l, input int steps);
		int n;
		int cnt;
		restart(l, 1'b0);
		n = divOf(l);
		lfsr = `SSCG_LFSR_SEED;
		cnt = 0;
		while (modStatus.dac === lfsr[6:0] && cnt < 4 * n + 80) begin
			step();
			cnt++;
		end
		repeat (n) step();
		for (int k = 0; k < steps; k++) begin
			lfsr = nextLfsr(lfsr);
			chkDac("dac", lfsr[6:0], modStatus.dac);
			chkDac("dacQ", lfsr[6:0], modStatusQ.dac);
			chkBit("active", 1'b1, modStatus.active);
			repeat (2 * n) step();
		end
	endtask : modRun

	initial begin
		srst = 1'b1;
		feedBack = 1'b0;
		level = SSCG_LVL_LOW;
		lastA = 1'b0;
		miscompares = 0;
		checked = 0;
		void'($urandom(1515));
		modRun(SSCG_LVL_LOW, 20);
		modRun(SSCG_LVL_FLOAT, 12);
		modRun(SSCG_LVL_HIGH, 8);
		restart(SSCG_LVL_LOW, 1'b1);
		repeat (140) step();
		chkBit("acOff", 1'b0, modStatus.active);
		chkBit("acOffQ", 1'b0, modStatusQ.active);
		chkDac("acMid", `SSCG_DAC_MID, modStatus.dac);
		feedBack = 1'b0;
		repeat (140) step();
		chkBit("acBack", 1'b1, modStatus.active);
		modRun(sscg_rate_lvl_t'($urandom_range(2, 0)), 4 + $urandom_range(8, 0));
		wrap_up();
	end

	// The whole sequence needs well under 10000 master cycles.
	initial begin
		#300000;
		miscompares++;
		wrap_up();
	end
endmodule : spread_spectrum_clock_gen_tb
